//--- rtl/csr_avg.sv
// Averages converter samples over one conversion period into a signed result.
`timescale 1ns/1ps
module csr_avg #(
  parameter int SW    = 18,
  parameter int FRAC  = 2,
  parameter int RW    = 16,
  parameter int MAXSH = 7
) (
  input wire logic clk,
  input wire logic rst,
  csr_avg_if.avg   bus
);
  localparam int ACC_W = SW + MAXSH + 1;
  localparam int CW    = MAXSH + 1;

  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] acc_next;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] bias;
  logic signed [ACC_W-1:0] quot;
  logic [CW-1:0]           cnt_reg;
  logic [CW-1:0]           cnt_next;
  logic [CW-1:0]           last;
  logic [RW-1:0]           res_reg;
  logic [RW-1:0]           res_next;
  logic                    vld_reg;
  logic                    vld_next;

  // ========================================================================
  // Accumulate and divide
  // ========================================================================
  always_comb begin
    sum      = acc_reg + ACC_W'(bus.sample);
    last     = CW'((1 << bus.shift) - 1);
    bias     = ACC_W'((1 << (bus.shift + FRAC)) - 1);
    // Biasing negative sums before the shift makes it cut toward zero.
    quot     = sum[ACC_W-1] ? ((sum + bias) >>> (bus.shift + FRAC))
                            : (sum >>> (bus.shift + FRAC));
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    vld_next = 1'b0;
    if (bus.restart) begin
      acc_next = '0;
      cnt_next = '0;
    end else if (bus.sample_valid) begin
      if (cnt_reg == last) begin
        acc_next = '0;
        cnt_next = '0;
        res_next = quot[RW-1:0];
        vld_next = 1'b1;
      end else begin
        acc_next = sum;
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      res_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      vld_reg <= vld_next;
    end
  end

  assign bus.result       = res_reg;
  assign bus.result_valid = vld_reg;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_close;
    !bus.restart && bus.sample_valid && cnt_reg == last;
  endsequence

  property p_sign_dir;
    s_close ##1 bus.result[RW-1] |-> $past(sum[ACC_W-1]);
  endproperty
  a_sign_dir: assert property (p_sign_dir) else $error("result sign without negative sum");

  property p_trunc_pos;
    s_close ##0 !sum[ACC_W-1] |=>
      bus.result == RW'($past(sum) >>> ($past(bus.shift) + FRAC));
  endproperty
  a_trunc_pos: assert property (p_trunc_pos) else $error("positive sum not cut down");

  // The negative case is checked through the magnitude, independent of the bias trick.
  property p_trunc_neg;
    s_close ##0 sum[ACC_W-1] |=>
      bus.result == RW'(-((-$past(sum)) >>> ($past(bus.shift) + FRAC)));
  endproperty
  a_trunc_neg: assert property (p_trunc_neg) else $error("negative sum not cut to zero");
endmodule

//--- rtl/csr_avg_if.sv
// Carrier between the readout top and its sample averager.
`timescale 1ns/1ps
interface csr_avg_if #(
  parameter int SW = 18,
  parameter int RW = 16
);
  logic signed [SW-1:0] sample;
  logic                 sample_valid;
  logic [2:0]           shift;
  logic                 restart;
  logic [RW-1:0]        result;
  logic                 result_valid;

  modport ctrl (output sample, output sample_valid, output shift, output restart,
                input result, input result_valid);
  modport avg  (input sample, input sample_valid, input shift, input restart,
                output result, output result_valid);
endinterface

//--- rtl/csr_pkg.sv
// Types shared by the current sense readout.
package csr_pkg;

  // ========================================================================
  // Field encodings
  // ========================================================================
  typedef enum logic [1:0] {
    CSR_GAIN_X5,
    CSR_GAIN_X25A,
    CSR_GAIN_X25B,
    CSR_GAIN_X51
  } csr_gain_e;

  typedef enum logic [1:0] {
    CSR_FILT_STD,
    CSR_FILT_NARROW,
    CSR_FILT_MID,
    CSR_FILT_WIDE
  } csr_filt_e;

endpackage

//--- rtl/csr_regs.svh
// Register offsets, field positions, reset values and fixed figures of the readout.
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// ==========================================================================
// Configuration register
// ==========================================================================
`define CSR_CFG_ADDR       8'h00
`define CSR_CFG_RESET      8'h00
`define CSR_GAIN_LSB       0
`define CSR_GAIN_MSB       1
`define CSR_FILT_LSB       2
`define CSR_FILT_MSB       3

// ==========================================================================
// Amplifier gains and code weight
// ==========================================================================
`define CSR_GAIN_X5        6'h05
`define CSR_GAIN_X25       6'h19
`define CSR_GAIN_X51       6'h33
// Converter code weight in units of 10 nV (68.66 uV).
`define CSR_ADC_LSB_10NV   13'h1_AD2

// ==========================================================================
// Converter rate and decimation per filter setting (log2 of samples averaged)
// ==========================================================================
`define CSR_STD_RATE_HZ    4000
`define CSR_SH_STD         3'h6
`define CSR_SH_NARROW      3'h7
`define CSR_SH_MID         3'h5
`define CSR_SH_WIDE        3'h4

`endif

//--- rtl/csr_top.sv
// Current sense readout: configuration register, gain decode and result register.
`timescale 1ns/1ps
`include "csr_regs.svh"

// Behaviour
// - Gain field at 00h: 00 gives 5, 01 and 10 give 25, 11 gives 51.
// - Filter field at 00h picks one of four filters, setting rate and response.
// - Converter results are 16 bits, produced at 4 kHz on the standard filter; the samples taken here are 18 bits with 2 fraction bits.
// - Result register is 16 bits: sign bit then 15 value bits in code units.
// - Result MSB gives current direction; the other fifteen bits give the value.
// - Fraction below one code weight is truncated, never rounded.
// - Input-referred code weight is 68.66 uV divided by the selected gain.
// - Negative currents appear as two's complement values of the result.
// - Each period's average current is written to the result and passed on.
module csr_top #(
  parameter int SW    = 18,
  parameter int FRAC  = 2,
  parameter int RW    = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [7:0]           cfg_wdata,
  output logic      [7:0]           cfg_rdata,
  input  wire logic signed [SW-1:0] conv_sample,
  input  wire logic                 conv_valid,
  output logic      [1:0]           amp_gain_sel,
  output logic      [5:0]           amp_gain_value,
  output logic      [12:0]          code_weight_10nv,
  output logic      [RW-1:0]        measured_current_result,
  output logic                      result_valid
);
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [5:0]  gain_reg;
  logic [5:0]  gain_next;
  logic [12:0] weight_reg;
  logic [12:0] weight_next;
  logic        cfg_hit;
  logic [2:0]  dec_shift;

  csr_avg_if #(.SW(SW), .RW(RW)) avg_bus ();

  // ========================================================================
  // Configuration register and its decodes
  // ========================================================================
  assign cfg_hit = cfg_wr && (cfg_addr == `CSR_CFG_ADDR);

  always_comb begin
    cfg_next   = cfg_hit ? cfg_wdata : cfg_reg;
    rdata_next = rdata_reg;
    if (cfg_rd) begin
      rdata_next = (cfg_addr == `CSR_CFG_ADDR) ? cfg_reg : 8'h00;
    end
    unique case (csr_pkg::csr_gain_e'(cfg_next[`CSR_GAIN_MSB:`CSR_GAIN_LSB]))
      csr_pkg::CSR_GAIN_X5:   gain_next = `CSR_GAIN_X5;
      csr_pkg::CSR_GAIN_X25A: gain_next = `CSR_GAIN_X25;
      csr_pkg::CSR_GAIN_X25B: gain_next = `CSR_GAIN_X25;
      csr_pkg::CSR_GAIN_X51:  gain_next = `CSR_GAIN_X51;
    endcase
    // Truncated like the result itself, so 25 reads 274 and not 275.
    weight_next = `CSR_ADC_LSB_10NV / 13'(gain_next);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg    <= `CSR_CFG_RESET;
      rdata_reg  <= 8'h00;
      gain_reg   <= `CSR_GAIN_X5;
      weight_reg <= `CSR_ADC_LSB_10NV / 13'(`CSR_GAIN_X5);
    end else begin
      cfg_reg    <= cfg_next;
      rdata_reg  <= rdata_next;
      gain_reg   <= gain_next;
      weight_reg <= weight_next;
    end
  end

  // ========================================================================
  // Filter selection steers the decimation length
  // ========================================================================
  always_comb begin
    unique case (csr_pkg::csr_filt_e'(cfg_reg[`CSR_FILT_MSB:`CSR_FILT_LSB]))
      csr_pkg::CSR_FILT_STD:    dec_shift = `CSR_SH_STD;
      csr_pkg::CSR_FILT_NARROW: dec_shift = `CSR_SH_NARROW;
      csr_pkg::CSR_FILT_MID:    dec_shift = `CSR_SH_MID;
      csr_pkg::CSR_FILT_WIDE:   dec_shift = `CSR_SH_WIDE;
    endcase
  end

  // A period that straddles a gain or filter change would mix two scales,
  // so such a write throws the partial period away.
  assign avg_bus.restart      = cfg_hit && (cfg_wdata[3:0] != cfg_reg[3:0]);
  assign avg_bus.sample       = conv_sample;
  assign avg_bus.sample_valid = conv_valid;
  assign avg_bus.shift        = dec_shift;

  csr_avg #(.SW(SW), .FRAC(FRAC), .RW(RW), .MAXSH(7)) u_avg (
    .clk (clk),
    .rst (rst),
    .bus (avg_bus)
  );

  assign cfg_rdata               = rdata_reg;
  assign amp_gain_sel            = cfg_reg[`CSR_GAIN_MSB:`CSR_GAIN_LSB];
  assign amp_gain_value          = gain_reg;
  assign code_weight_10nv        = weight_reg;
  // The whole word is replaced in one edge, so any read sees one period.
  assign measured_current_result = avg_bus.result;
  assign result_valid            = avg_bus.result_valid;

  // ========================================================================
  // Checks
  // ========================================================================
  logic [8:0] seen_reg;
  logic [8:0] seen_next;

  // A sample that arrives with the result strobe already opens the next period.
  always_comb begin
    seen_next = seen_reg;
    if (avg_bus.restart) begin
      seen_next = 9'h000;
    end else if (result_valid) begin
      seen_next = conv_valid ? 9'h001 : 9'h000;
    end else if (conv_valid) begin
      seen_next = seen_reg + 9'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_reg <= 9'h000;
    end else begin
      seen_reg <= seen_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cfg_write;
    cfg_hit;
  endsequence

  sequence s_cfg_read;
    cfg_rd && cfg_addr == `CSR_CFG_ADDR;
  endsequence

  property p_cfg_store;
    s_cfg_write |=> cfg_reg == $past(cfg_wdata);
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("config write not stored");

  property p_gain_x5;
    amp_gain_sel == 2'h0 |-> amp_gain_value == 6'h05;
  endproperty
  a_gain_x5: assert property (p_gain_x5) else $error("gain code 00 not 5");

  property p_gain_x25;
    (amp_gain_sel == 2'h1 || amp_gain_sel == 2'h2) |-> amp_gain_value == 6'h19;
  endproperty
  a_gain_x25: assert property (p_gain_x25) else $error("gain code 01/10 not 25");

  property p_gain_x51;
    s_cfg_write ##0 cfg_wdata[1:0] == 2'h3 |=>
      amp_gain_value == 6'h33 ##1 ($past(cfg_hit) || amp_gain_value == 6'h33);
  endproperty
  a_gain_x51: assert property (p_gain_x51) else $error("gain code 11 not 51");

  property p_filt_len;
    result_valid |-> seen_reg == (9'h001 << $past(dec_shift));
  endproperty
  a_filt_len: assert property (p_filt_len) else $error("period length wrong for filter");

  property p_std_64;
    result_valid && cfg_reg[3:2] == 2'h0 && $stable(cfg_reg) |-> seen_reg == 9'h040;
  endproperty
  a_std_64: assert property (p_std_64) else $error("standard filter not 64 samples");

  property p_weight;
    amp_gain_value == 6'h05 |-> code_weight_10nv == 13'h0_55D;
  endproperty
  a_weight: assert property (p_weight) else $error("code weight at gain 5 not 13.73 uV");

  property p_hold;
    !result_valid |-> $stable(measured_current_result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed outside update");

  property p_single;
    result_valid |=> !result_valid;
  endproperty
  a_single: assert property (p_single) else $error("result update not a single pulse");

  property p_restart;
    avg_bus.restart |=> !result_valid [*8];
  endproperty
  a_restart: assert property (p_restart) else $error("result right after restart");

  property p_sel;
    s_cfg_write |=> amp_gain_sel == $past(cfg_wdata[`CSR_GAIN_MSB:`CSR_GAIN_LSB]);
  endproperty
  a_sel: assert property (p_sel) else $error("gain code not passed on");

  property p_rd_cfg;
    s_cfg_read |=> cfg_rdata == $past(cfg_reg);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read data wrong");

  property p_rd_unmapped;
    cfg_rd && cfg_addr != `CSR_CFG_ADDR |=> cfg_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_weight_25;
    amp_gain_value == 6'h19 |-> code_weight_10nv == 13'h0_112;
  endproperty
  a_weight_25: assert property (p_weight_25) else $error("code weight at gain 25 wrong");

  property p_weight_51;
    amp_gain_value == 6'h33 |-> code_weight_10nv == 13'h0_086;
  endproperty
  a_weight_51: assert property (p_weight_51) else $error("code weight at gain 51 wrong");
endmodule

//--- verif/csr_conv_model.sv
// Converter model that feeds signed samples to the readout.
`timescale 1ns/1ps
module csr_conv_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic signed [17:0] value,
  input  wire logic [7:0]         count,
  input  wire logic [3:0]         gap,
  output logic signed [17:0]      conv_sample,
  output logic                    conv_valid,
  output logic                    busy
);
  int left;
  int idle;

  assign busy = (left != 0);

  // Between strobes the sample bus toggles, so a stale value is never taken for data.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      left        <= 0;
      idle        <= 0;
      conv_valid  <= 1'b0;
      conv_sample <= 18'h0_0000;
    end else begin
      conv_valid  <= 1'b0;
      conv_sample <= ~conv_sample;
      if (start && left == 0) begin
        left <= count;
        idle <= 0;
      end else if (left != 0 && idle != 0) begin
        idle <= idle - 1;
      end else if (left != 0) begin
        conv_valid  <= 1'b1;
        conv_sample <= value;
        left        <= left - 1;
        idle        <= gap;
      end
    end
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the current sense readout.
`timescale 1ns/1ps
module testbench;
  logic               clk;
  logic               rst;
  logic               cfg_wr;
  logic               cfg_rd;
  logic [7:0]         cfg_addr;
  logic [7:0]         cfg_wdata;
  logic [7:0]         cfg_rdata;
  logic signed [17:0] conv_sample;
  logic               conv_valid;
  logic [1:0]         amp_gain_sel;
  logic [5:0]         amp_gain_value;
  logic [12:0]        code_weight_10nv;
  logic [15:0]        measured_current_result;
  logic               result_valid;
  logic               start;
  logic signed [17:0] value;
  logic [7:0]         count;
  logic [3:0]         gap;
  logic               busy;
  int                 error_cnt = 0;
  int                 checks = 0;
  int                 pulses = 0;
  int                 c;
  int                 v;
  int                 gains[4] = '{5, 25, 25, 51};
  int                 wts[4] = '{1373, 274, 274, 134};
  int                 ks[4] = '{6, 7, 5, 4};

  csr_top i_dut (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .conv_sample(conv_sample), .conv_valid(conv_valid), .amp_gain_sel(amp_gain_sel),
    .amp_gain_value(amp_gain_value), .code_weight_10nv(code_weight_10nv),
    .measured_current_result(measured_current_result), .result_valid(result_valid));
  csr_conv_model i_conv (.clk(clk), .rst(rst), .start(start), .value(value),
    .count(count), .gap(gap), .conv_sample(conv_sample), .conv_valid(conv_valid),
    .busy(busy));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (result_valid === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic summarize();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
  endtask

  task automatic cfg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk(16'(cfg_rdata), 16'(e));
  endtask

  task automatic send(input logic [17:0] sv, input int n, input int g);
    int i;
    @(posedge clk);
    start <= 1'b1;
    value <= sv;
    count <= 8'(n);
    gap   <= 4'(g);
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 2000 && busy; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy) begin
      error_cnt++;
      summarize();
    end
  endtask

  // A full period must give exactly one strobe and the expected value.
  task automatic run(input logic [17:0] sv, input int n, input int g, input logic [15:0] e);
    int i;
    int p0;
    p0 = pulses;
    send(sv, n, g);
    for (i = 0; i < 8 && result_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(16'(result_valid), 16'h0001);
    if (result_valid !== 1'b1) begin
      summarize();
    end
    chk(measured_current_result, e);
    @(posedge clk);
    #1;
    chk(16'(result_valid), 16'h0000);
    chk(16'(pulses - p0), 16'h0001);
    chk(measured_current_result, e);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst       = 1'b1;
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
    start     = 1'b0;
    value     = 18'h0_0000;
    count     = 8'h00;
    gap       = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'(amp_gain_value), 16'h0005);
    chk(16'(code_weight_10nv), 16'h055D);
    chk(measured_current_result, 16'h0000);
    cfg_read(8'h00, 8'h00);
    for (c = 0; c < 4; c++) begin
      cfg_write(8'h00, 8'(c) | 8'h0C);
      chk(16'(amp_gain_sel), 16'(c));
      chk(16'(amp_gain_value), 16'(gains[c]));
      chk(16'(code_weight_10nv), 16'(wts[c]));
      cfg_read(8'h00, 8'(c) | 8'h0C);
    end
    cfg_write(8'h05, 8'hF0);
    cfg_read(8'h05, 8'h00);
    cfg_read(8'h00, 8'h0F);
    for (c = 0; c < 4; c++) begin
      cfg_write(8'h00, 8'(c << 2));
      v = (c % 2 == 0) ? 22 : -22;
      run(18'(v), 1 << ks[c], c, 16'(v / 4));
    end
    cfg_write(8'h00, 8'h0C);
    run(18'h1_FFFF, 16, 0, 16'h7FFF);
    run(18'h2_0000, 16, 0, 16'h8000);
    run(18'h0_0005, 16, 1, 16'h0001);
    run(18'h3_FFFB, 16, 2, 16'hFFFF);
    send(18'h0_0028, 8, 0);
    cfg_write(8'h00, 8'h0D);
    run(18'h0_0008, 16, 0, 16'h0002);
    summarize();
  end
endmodule
